// [chfc_regs.sv]
// Charger detection flag and control seven register bank
// Contract
// RULE1: Set detection-done flag when select-pin or data-line detection finishes.
// RULE2: Trim 00 none, 01 plus 8mV, 10 minus 8mV, 11 minus 16mV.
// RULE3: Current select 0 gives 90mA trickle, 1 gives 30mA.
// RULE4: Current select 0 gives 12A discharge peak, 1 gives 9A.
// RULE5: Status pattern: off, low, blink 1s/1s, blink 1s/3s.
// RULE6: Status pattern only acts while charge monitor select equals 01.
// RULE7: Offset 00 3.9V, 01 5.9V, 10 7.5V, 11 10.5V.
// RULE8: Host programs and reads these registers over I2C.
// RULE9: Register reset restores defaults, restarts safety timer, self-clears.
// RULE10: Watchdog resets all fields but offset; register reset resets all.
// RULE11: Reserved bits read stable; writes to them change nothing.
`timescale 1ns/1ps
module chfc_regs
    import chfc_pkg::*;
#(
    parameter logic [31:0] SEC_CYCLES = 32'(CHFC_SEC_CYCLES)
) (
    // Clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                resetn_i,
    // Register port from the I2C slave
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic                reg_wr_i,
    input  wire logic [7:0]          reg_wdata_i,
    input  wire logic                reg_rd_i,
    output logic [7:0]               reg_rdata_o,
    output logic                     reg_rvalid_o,
    // Reset sources
    input  wire logic                reg_reset_req_i,
    input  wire logic                watchdog_expired_i,
    output logic                     safety_timer_restart_o,
    // Detection
    input  wire logic                vbus_plug_in_i,
    input  wire logic                force_line_detection_i,
    input  wire logic                detect_finished_i,
    // Charge monitor select
    input  wire logic [1:0]          charge_monitor_select_i,
    // Decoded controls
    output logic signed [5:0]        charge_voltage_trim_mv_o,
    output logic                     trickle_and_discharge_limit_sel_o,
    output logic [6:0]               trickle_current_ma_o,
    output logic [3:0]               discharge_peak_a_o,
    output logic [13:0]              input_voltage_limit_offset_mv_o,
    // Status pin
    output logic                     stat_pull_low_o,
    output logic                     stat_oe_o
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        // Control fields
        logic [1:0]         trim;
        logic               rsvd;
        logic               cursel;
        logic [1:0]         stat;
        logic [1:0]         vos;
        // Detection flag
        logic               done;
        // Read port and timer pulse
        logic [7:0]         rdata;
        logic               rvalid;
        logic               tmr_rst;
        // Decoded outputs
        logic signed [5:0]  trim_mv;
        logic [6:0]         trickle;
        logic [3:0]         peak;
        logic [13:0]        vos_mv;
        // Synchroniser and edge detect
        logic               det_sync1;
        logic               det_sync2;
        logic               det_prev;
    } chfc_regs_st_t;

    chfc_regs_st_t s_q, s_d;
    logic [7:0]    ctrl_word;
    logic          det_rise;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // ------------------------------------------------------------------
        // Detection flag
        // ------------------------------------------------------------------
        // Detection strobe arrives from the analog domain; sync before use
        s_d.det_sync1 = detect_finished_i;
        s_d.det_sync2 = s_q.det_sync1;
        s_d.det_prev  = s_q.det_sync2;
        det_rise      = s_q.det_sync2 && !s_q.det_prev;

        // New plug-in or forced detection starts a fresh cycle; finish wins
        if (vbus_plug_in_i || force_line_detection_i) begin
            s_d.done = 1'b0;
        end
        // A rise landing with a clear still sets the flag
        if (det_rise) begin
            s_d.done = 1'b1; // RULE1
        end

        // ------------------------------------------------------------------
        // Host write
        // ------------------------------------------------------------------
        // Host write; reserved bit keeps a stable zero
        // Only the control byte is writable; flag byte writes fall away
        if (reg_wr_i && reg_addr_i == CHFC_CHARGER_CONTROL_SEVEN_ADDR) begin // RULE8
            s_d.trim   = reg_wdata_i[CHFC_TRIM_MSB:CHFC_TRIM_LSB];
            s_d.cursel = reg_wdata_i[CHFC_CURSEL_BIT];
            s_d.stat   = reg_wdata_i[CHFC_STAT_MSB:CHFC_STAT_LSB];
            s_d.vos    = reg_wdata_i[CHFC_VOS_MSB:CHFC_VOS_LSB];
        end
        s_d.rsvd = CHFC_CONTROL_SEVEN_RESET[CHFC_RSVD_BIT]; // RULE11

        // ------------------------------------------------------------------
        // Reset sources
        // ------------------------------------------------------------------
        // Resets override a simultaneous write
        // Watchdog spares the offset so a host timeout keeps the input limit
        if (reg_reset_req_i || watchdog_expired_i) begin // RULE10
            s_d.trim   = CHFC_CONTROL_SEVEN_RESET[CHFC_TRIM_MSB:CHFC_TRIM_LSB];
            s_d.cursel = CHFC_CONTROL_SEVEN_RESET[CHFC_CURSEL_BIT];
            s_d.stat   = CHFC_CONTROL_SEVEN_RESET[CHFC_STAT_MSB:CHFC_STAT_LSB];
        end
        if (reg_reset_req_i) begin // RULE9 RULE10
            s_d.vos = CHFC_CONTROL_SEVEN_RESET[CHFC_VOS_MSB:CHFC_VOS_LSB];
        end
        // Request bit lives upstream and self-clears; we pulse the timer once
        s_d.tmr_rst = reg_reset_req_i; // RULE9

        // ------------------------------------------------------------------
        // Read path
        // ------------------------------------------------------------------
        // Read path; reserved flag bits read zero
        // Idle cycles return zero so a stale byte never looks like data
        ctrl_word = {s_q.trim, s_q.rsvd, s_q.cursel, s_q.stat, s_q.vos};
        s_d.rvalid = reg_rd_i;
        s_d.rdata  = CHFC_ZERO_BYTE;
        if (reg_rd_i) begin
            case (reg_addr_i)
                CHFC_INPUT_DETECT_FLAG_ADDR: begin
                    s_d.rdata[CHFC_DETECT_DONE_BIT] = s_q.done; // RULE1 RULE11
                end
                CHFC_CHARGER_CONTROL_SEVEN_ADDR: begin
                    s_d.rdata = ctrl_word;
                end
                default: begin
                    s_d.rdata = CHFC_ZERO_BYTE;
                end
            endcase
        end

        // ------------------------------------------------------------------
        // Field decode
        // ------------------------------------------------------------------
        // Decode from next value so outputs track the fields without lag
        // Costs a longer next-state path, saves a cycle of output lag
        case (s_d.trim)
            CHFC_TRIM_PLUS8:   s_d.trim_mv = CHFC_TRIM_MV_PLUS8;   // RULE2
            CHFC_TRIM_MINUS8:  s_d.trim_mv = CHFC_TRIM_MV_MINUS8;  // RULE2
            CHFC_TRIM_MINUS16: s_d.trim_mv = CHFC_TRIM_MV_MINUS16; // RULE2
            default:           s_d.trim_mv = '0;
        endcase
        s_d.trickle = s_d.cursel ? CHFC_TRICKLE_MA_ALT : CHFC_TRICKLE_MA_DEF; // RULE3
        s_d.peak    = s_d.cursel ? CHFC_PEAK_A_ALT : CHFC_PEAK_A_DEF;         // RULE4
        case (s_d.vos)
            2'h1:    s_d.vos_mv = CHFC_VOS_MV_1; // RULE7
            2'h2:    s_d.vos_mv = CHFC_VOS_MV_2; // RULE7
            2'h3:    s_d.vos_mv = CHFC_VOS_MV_3; // RULE7
            default: s_d.vos_mv = CHFC_VOS_MV_0; // RULE7
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            // Decoded outputs start at the decode of the default fields
            s_q         <= '0;
            s_q.trickle <= CHFC_TRICKLE_MA_DEF;
            s_q.peak    <= CHFC_PEAK_A_DEF;
            s_q.vos_mv  <= CHFC_VOS_MV_0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Status pin
    // ------------------------------------------------------------------
    // Pattern timing lives in its own block so the bank stays flat
    // Select compare is same-clock, no synchroniser needed
    chfc_blink #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_blink (
        .sys_clk_i       (sys_clk_i),
        .resetn_i        (resetn_i),
        .active_i        (charge_monitor_select_i == CHFC_MON_STAT_SEL), // RULE6
        .pattern_i       (s_q.stat),
        .stat_pull_low_o (stat_pull_low_o),
        .stat_oe_o       (stat_oe_o)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Register port
    assign reg_rdata_o                       = s_q.rdata;
    assign reg_rvalid_o                      = s_q.rvalid;
    // Timer pulse and decoded controls
    assign safety_timer_restart_o            = s_q.tmr_rst;
    assign charge_voltage_trim_mv_o          = s_q.trim_mv;
    assign trickle_and_discharge_limit_sel_o = s_q.cursel;
    assign trickle_current_ma_o              = s_q.trickle;
    assign discharge_peak_a_o                = s_q.peak;
    assign input_voltage_limit_offset_mv_o   = s_q.vos_mv;

endmodule : chfc_regs

// [chfc_pkg.sv]
// Package with register map, field layout and timing constants of the flag/control bank
package chfc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] CHFC_INPUT_DETECT_FLAG_ADDR     = 8'h0E;
    localparam logic [7:0] CHFC_CHARGER_CONTROL_SEVEN_ADDR = 8'h0F;
    localparam logic [7:0] CHFC_CONTROL_SEVEN_RESET        = 8'h00;
    localparam logic [7:0] CHFC_ZERO_BYTE                  = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CHFC_DETECT_DONE_BIT = 7;
    localparam int CHFC_TRIM_MSB        = 7;
    localparam int CHFC_TRIM_LSB        = 6;
    localparam int CHFC_RSVD_BIT        = 5;
    localparam int CHFC_CURSEL_BIT      = 4;
    localparam int CHFC_STAT_MSB        = 3;
    localparam int CHFC_STAT_LSB        = 2;
    localparam int CHFC_VOS_MSB         = 1;
    localparam int CHFC_VOS_LSB         = 0;

    // ------------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] CHFC_TRIM_NONE      = 2'h0;
    localparam logic [1:0] CHFC_TRIM_PLUS8     = 2'h1;
    localparam logic [1:0] CHFC_TRIM_MINUS8    = 2'h2;
    localparam logic [1:0] CHFC_TRIM_MINUS16   = 2'h3;
    localparam logic [1:0] CHFC_STAT_OFF       = 2'h0;
    localparam logic [1:0] CHFC_STAT_ON        = 2'h1;
    localparam logic [1:0] CHFC_STAT_BLINK_1_1 = 2'h2;
    localparam logic [1:0] CHFC_STAT_BLINK_1_3 = 2'h3;
    localparam logic [1:0] CHFC_MON_STAT_SEL   = 2'h1;

    // Signed trim in mV, trickle current in mA, peak current in A, offset in mV
    localparam logic signed [5:0] CHFC_TRIM_MV_PLUS8   = 6'sh08;
    localparam logic signed [5:0] CHFC_TRIM_MV_MINUS8  = -6'sh08;
    localparam logic signed [5:0] CHFC_TRIM_MV_MINUS16 = -6'sh10;
    localparam logic [6:0]  CHFC_TRICKLE_MA_DEF = 7'h5A;
    localparam logic [6:0]  CHFC_TRICKLE_MA_ALT = 7'h1E;
    localparam logic [3:0]  CHFC_PEAK_A_DEF     = 4'hC;
    localparam logic [3:0]  CHFC_PEAK_A_ALT     = 4'h9;
    localparam logic [13:0] CHFC_VOS_MV_0       = 14'h0F3C;
    localparam logic [13:0] CHFC_VOS_MV_1       = 14'h170C;
    localparam logic [13:0] CHFC_VOS_MV_2       = 14'h1D4C;
    localparam logic [13:0] CHFC_VOS_MV_3       = 14'h2904;

    // ------------------------------------------------------------------
    // Blink timing
    // ------------------------------------------------------------------
    localparam longint CHFC_CLK_HZ       = 250000000;
    localparam longint CHFC_BLINK_ON_S   = 1;
    localparam longint CHFC_BLINK_OFF1_S = 1;
    localparam longint CHFC_BLINK_OFF3_S = 3;
    localparam longint CHFC_SEC_CYCLES   = CHFC_CLK_HZ;
    localparam int     CHFC_CNT_W        = 32;

endpackage : chfc_pkg

// [chfc_blink.sv]
// Status pin pattern generator with second-based blink timing
`timescale 1ns/1ps
module chfc_blink
    import chfc_pkg::*;
#(
    parameter logic [31:0] SEC_CYCLES = 32'(CHFC_SEC_CYCLES)
) (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    // Pattern select
    input  wire logic       active_i,
    input  wire logic [1:0] pattern_i,
    // Pin drive
    output logic            stat_pull_low_o,
    output logic            stat_oe_o
);
    typedef struct packed {
        logic [31:0] cyc;
        logic [1:0]  sec;
        logic        low;
        logic        oe;
    } chfc_blink_st_t;

    chfc_blink_st_t s_q, s_d;
    logic [1:0] period_s;
    logic       blink;

    always_comb begin
        s_d      = s_q;
        blink    = 1'b0;
        period_s = 2'(CHFC_BLINK_ON_S + CHFC_BLINK_OFF1_S - 1);
        if (pattern_i == CHFC_STAT_BLINK_1_3) begin
            period_s = 2'(CHFC_BLINK_ON_S + CHFC_BLINK_OFF3_S - 1);
        end
        // Seconds counter free runs so pattern changes take effect at once
        if (s_q.cyc >= SEC_CYCLES - 32'h1) begin
            s_d.cyc = 32'h0;
            s_d.sec = (s_q.sec >= period_s) ? 2'h0 : s_q.sec + 2'h1;
        end else begin
            s_d.cyc = s_q.cyc + 32'h1;
        end
        case (pattern_i)
            CHFC_STAT_BLINK_1_1,
            CHFC_STAT_BLINK_1_3: blink = 1'b1;
            default:             blink = 1'b0;
        endcase
        // Pin only driven low; open drain otherwise
        if (!active_i || pattern_i == CHFC_STAT_OFF) begin // RULE5 RULE6
            s_d.low = 1'b0;
        end else if (pattern_i == CHFC_STAT_ON) begin // RULE5
            s_d.low = 1'b1;
        end else begin
            s_d.low = blink && (s_q.sec < 2'(CHFC_BLINK_ON_S)); // RULE5
        end
        s_d.oe = s_d.low;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign stat_pull_low_o = s_q.low;
    assign stat_oe_o       = s_q.oe;

endmodule : chfc_blink

// [chfc_chk.sv]
// Assertion checker for the flag and control register bank
`timescale 1ns/1ps
module chfc_chk
    import chfc_pkg::*;
(
    input wire logic              sys_clk_i,
    input wire logic              resetn_i,
    input wire logic [7:0]        reg_addr_i,
    input wire logic              reg_wr_i,
    input wire logic [7:0]        reg_wdata_i,
    input wire logic              reg_rd_i,
    input wire logic              reg_rvalid_o,
    input wire logic              reg_reset_req_i,
    input wire logic              watchdog_expired_i,
    input wire logic              safety_timer_restart_o,
    input wire logic [1:0]        charge_monitor_select_i,
    input wire logic signed [5:0] charge_voltage_trim_mv_o,
    input wire logic              trickle_and_discharge_limit_sel_o,
    input wire logic [6:0]        trickle_current_ma_o,
    input wire logic [3:0]        discharge_peak_a_o,
    input wire logic [13:0]       input_voltage_limit_offset_mv_o,
    input wire logic              stat_pull_low_o,
    input wire logic              stat_oe_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);
    function automatic logic signed [5:0] tmv(input logic [7:0] w);
        case (w[7:6])
            2'h1: return CHFC_TRIM_MV_PLUS8;
            2'h2: return CHFC_TRIM_MV_MINUS8;
            2'h3: return CHFC_TRIM_MV_MINUS16;
            default: return 6'sh00;
        endcase
    endfunction : tmv
    a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read strobe not answered");
    a_no_stray_valid: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("read valid without strobe");
    a_timer_restart: assert property (reg_reset_req_i |=> safety_timer_restart_o)
        else $error("safety timer not restarted");
    a_reset_defaults: assert property (reg_reset_req_i |=> charge_voltage_trim_mv_o == 6'sh00
        && !trickle_and_discharge_limit_sel_o && input_voltage_limit_offset_mv_o == CHFC_VOS_MV_0)
        else $error("register reset left fields set");
    a_trickle_map: assert property (trickle_current_ma_o ==
        (trickle_and_discharge_limit_sel_o ? 7'h1E : 7'h5A)) else $error("trickle current wrong");
    a_peak_map: assert property (discharge_peak_a_o ==
        (trickle_and_discharge_limit_sel_o ? 4'h9 : 4'hC)) else $error("peak current wrong");
    a_trim_write: assert property (reg_wr_i && reg_addr_i == CHFC_CHARGER_CONTROL_SEVEN_ADDR
        && !reg_reset_req_i && !watchdog_expired_i
        |=> charge_voltage_trim_mv_o == tmv($past(reg_wdata_i))) else $error("trim not decoded");
    a_wd_offset: assert property (watchdog_expired_i && !reg_reset_req_i && !reg_wr_i
        |=> $stable(input_voltage_limit_offset_mv_o)) else $error("watchdog moved offset");
    a_wd_clear: assert property (watchdog_expired_i |=> charge_voltage_trim_mv_o == 6'sh00
        && !trickle_and_discharge_limit_sel_o) else $error("watchdog left fields set");
    a_pin_gate: assert property ((charge_monitor_select_i != CHFC_MON_STAT_SEL)[*3]
        |-> !stat_oe_o) else $error("pin driven while pattern gated");
    a_oe_pair: assert property (stat_oe_o == stat_pull_low_o)
        else $error("pin enable and level disagree");
    c_read: cover property (reg_rd_i ##1 reg_rvalid_o);
    c_watchdog: cover property (watchdog_expired_i);
    c_pin_low: cover property ($rose(stat_pull_low_o));
endmodule : chfc_chk
bind chfc_regs chfc_chk u_chk (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rvalid_o(reg_rvalid_o),
    .reg_reset_req_i(reg_reset_req_i), .watchdog_expired_i(watchdog_expired_i),
    .safety_timer_restart_o(safety_timer_restart_o),
    .charge_monitor_select_i(charge_monitor_select_i),
    .charge_voltage_trim_mv_o(charge_voltage_trim_mv_o),
    .trickle_and_discharge_limit_sel_o(trickle_and_discharge_limit_sel_o),
    .trickle_current_ma_o(trickle_current_ma_o), .discharge_peak_a_o(discharge_peak_a_o),
    .input_voltage_limit_offset_mv_o(input_voltage_limit_offset_mv_o),
    .stat_pull_low_o(stat_pull_low_o), .stat_oe_o(stat_oe_o));

// [chfc_host.sv]
// Host model issuing register strobes in place of the serial slave
`timescale 1ns/1ps
module chfc_host (
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic [7:0]      addr_o,
    output logic            wr_o,
    output logic [7:0]      wdata_o,
    output logic            rd_o
);
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
        rd_o = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge sys_clk_i);
        wr_o = 1'b0;
        wdata_o = ~d; // Stale data is not left on the bus
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge sys_clk_i);
        rd_o = 1'b0;
        d = 8'hXX; // Unknown on timeout so the compare fails
        for (int n = 0; n < 4; n++) begin
            if (rvalid_i === 1'b1) begin
                d = rdata_i;
                break;
            end
            @(negedge sys_clk_i);
        end
    endtask : rd
endmodule : chfc_host

// [tb_chfc_regs.sv]
// Self-checking bench for the flag and control register bank
`timescale 1ns/1ps
module tb_chfc_regs;
    import chfc_pkg::*;
    logic clk = 1'b0, resetn_i = 1'b0, rreq = 1'b0, wd = 1'b0, plug = 1'b0, force_d = 1'b0;
    logic det = 1'b0, wr, rd, rv, rst_o, sel, pl, oe;
    logic [1:0]  mon = 2'h0;
    logic [7:0]  addr, wdat, rdat, d;
    logic signed [5:0] trim;
    logic [6:0]  tric;
    logic [3:0]  peak;
    logic [13:0] vos;
    int fails = 0, tests_run = 0, n;
    logic [5:0]  t_exp [4] = '{6'h00, 6'h08, 6'h38, 6'h30};
    logic [13:0] v_exp [4] = '{14'h0F3C, 14'h170C, 14'h1D4C, 14'h2904};
    always #2 clk = ~clk;
    chfc_host u_host (.sys_clk_i(clk), .rdata_i(rdat), .rvalid_i(rv), .addr_o(addr), .wr_o(wr),
        .wdata_o(wdat), .rd_o(rd));
    chfc_regs #(.SEC_CYCLES(32'h8)) u_dut (.sys_clk_i(clk), .resetn_i(resetn_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdat), .reg_rd_i(rd), .reg_rdata_o(rdat),
        .reg_rvalid_o(rv), .reg_reset_req_i(rreq), .watchdog_expired_i(wd),
        .safety_timer_restart_o(rst_o), .vbus_plug_in_i(plug), .force_line_detection_i(force_d),
        .detect_finished_i(det), .charge_monitor_select_i(mon), .charge_voltage_trim_mv_o(trim),
        .trickle_and_discharge_limit_sel_o(sel), .trickle_current_ma_o(tric),
        .discharge_peak_a_o(peak), .input_voltage_limit_offset_mv_o(vos),
        .stat_pull_low_o(pl), .stat_oe_o(oe));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    initial begin
        repeat (5000) @(posedge clk);
        fails++; // Hang guard
        final_report();
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(negedge clk);
        resetn_i = 1'b1;
        u_host.rd(8'h0F, d);
        chk(d, 8'h00);
        for (int i = 0; i < 4; i++) begin
            u_host.wr(8'h0F, {i[1:0], 1'b1, i[0], i[1:0], i[1:0]});
            u_host.rd(8'h0F, d);
            chk(d, {i[1:0], 1'b0, i[0], i[1:0], i[1:0]});
            chk({10'h0, trim}, t_exp[i]);
            chk(vos, v_exp[i]);
            chk(tric, i[0] ? 7'h1E : 7'h5A);
            chk(peak, i[0] ? 4'h9 : 4'hC);
            chk(sel, i[0]);
            chk(oe, 1'b0);
        end
        pulse(wd);
        u_host.rd(8'h0F, d);
        chk(d, 8'h03);
        pulse(rreq);
        chk(rst_o, 1'b1);
        u_host.rd(8'h0F, d);
        chk(d, 8'h00);
        u_host.wr(8'h0E, 8'hFF);
        u_host.rd(8'h0E, d);
        chk(d, 8'h00);
        u_host.rd(8'h20, d);
        chk(d, 8'h00);
        for (int j = 0; j < 2; j++) begin
            det = 1'b0;
            repeat (4) @(negedge clk);
            det = 1'b1;
            repeat (6) @(negedge clk);
            u_host.wr(8'h0E, 8'h00);
            u_host.rd(8'h0E, d);
            chk(d, 8'h80);
            if (j == 0) pulse(force_d);
            else pulse(plug);
            u_host.rd(8'h0E, d);
            chk(d, 8'h00);
        end
        mon = 2'h1;
        u_host.wr(8'h0F, 8'h04);
        repeat (3) @(negedge clk);
        chk({oe, pl}, 2'h3);
        mon = 2'h2; // Gating must win even with a pattern stored
        repeat (3) @(negedge clk);
        chk(oe, 1'b0);
        mon = 2'h1;
        for (int p = 2; p < 4; p++) begin
            u_host.wr(8'h0F, {4'h0, p[1:0], 2'h0});
            repeat (4) @(negedge clk);
            n = 0;
            repeat (64) begin
                @(negedge clk);
                n += int'(pl === 1'b1);
            end
            chk(n[15:0], p == 2 ? 16'h20 : 16'h10);
        end
        u_host.wr(8'h0F, 8'h00);
        repeat (3) @(negedge clk);
        chk(oe, 1'b0);
        final_report();
    end
endmodule : tb_chfc_regs
